/* File: ddrc_cfg.svh */
// Constants for the DDR2 command controller: offsets, fields, resets and timing counts.
`ifndef DDRC_CFG_SVH
`define DDRC_CFG_SVH
`define DDRC_CLK_PS         25000
`define DDRC_CEIL(t)        (((t) + `DDRC_CLK_PS - 1) / `DDRC_CLK_PS)
`define DDRC_T_RCD_PS       15000
`define DDRC_T_RP_PS        15000
`define DDRC_T_WR_PS        15000
`define DDRC_T_WTR_PS       7500
`define DDRC_T_RFC_PS       127500
`define DDRC_T_XSNR_PS      137500
`define DDRC_RCD_CYC        `DDRC_CEIL(`DDRC_T_RCD_PS)
`define DDRC_RP_CYC         `DDRC_CEIL(`DDRC_T_RP_PS)
`define DDRC_WR_CYC         `DDRC_CEIL(`DDRC_T_WR_PS)
`define DDRC_RFC_CYC        `DDRC_CEIL(`DDRC_T_RFC_PS)
`define DDRC_XSNR_CYC       `DDRC_CEIL(`DDRC_T_XSNR_PS)
`define DDRC_WTR_RAW        `DDRC_CEIL(`DDRC_T_WTR_PS)
`define DDRC_WTR_CYC        ((`DDRC_WTR_RAW > 2) ? `DDRC_WTR_RAW : 2)
`define DDRC_MRD_CYC        2
`define DDRC_CKE_WAIT       2
`define DDRC_REG_CMD        8'h00
`define DDRC_REG_ADDR       8'h04
`define DDRC_REG_CFG        8'h08
`define DDRC_REG_STATUS     8'h0C
`define DDRC_REG_BANKS      8'h10
`define DDRC_CMD_AP_BIT     4
`define DDRC_CMD_BANK_LSB   8
`define DDRC_CFG_CL_LSB     4
`define DDRC_CFG_CL_RST     3'h3
`define DDRC_CL_MIN         3'h3
`define DDRC_CL_MAX         3'h7
`define DDRC_ST_REFUSED_BIT 1
`endif

/* File: ddrc_pkg.sv */
// Types shared by the DDR2 command controller and its bank trackers.
package ddrc_pkg;
  typedef enum logic [3:0] {
    op_nop, op_mrs, op_act, op_rd, op_wr, op_pre, op_ref, op_sre, op_srx
  } ddrc_op_e;
  typedef enum logic [2:0] {
    bk_idle, bk_activating, bk_active, bk_reading, bk_writing, bk_precharging
  } ddrc_bank_e;
  typedef logic [7:0] ddrc_cnt_t;
endpackage : ddrc_pkg

/* File: ddrc_bank.sv */
// State tracker for one DDR2 bank as seen from the controller.
`timescale 1ns/1ps
`default_nettype none
`include "ddrc_cfg.svh"
module ddrc_bank (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 act,
  input  wire logic                 rd,
  input  wire logic                 wr,
  input  wire logic                 pre,
  input  wire logic                 ap,
  input  wire ddrc_pkg::ddrc_cnt_t  rd_len,
  input  wire ddrc_pkg::ddrc_cnt_t  wr_len,
  output var  ddrc_pkg::ddrc_bank_e state,
  output var  logic                 ap_pend
);
  ddrc_pkg::ddrc_cnt_t cnt;

  // A state lasts exactly its count; the counter loads one less, since the state ends when it reads zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state   <= ddrc_pkg::bk_idle;
      cnt     <= 8'h00;
      ap_pend <= 1'b0;
    end else begin
      if (cnt != 8'h00) cnt <= cnt - 8'h01;
      unique case (state)
        ddrc_pkg::bk_idle, ddrc_pkg::bk_precharging: begin
          if (act) begin
            state <= ddrc_pkg::bk_activating;
            cnt   <= 8'(`DDRC_RCD_CYC - 1);
          end else if (pre) begin
            state <= ddrc_pkg::bk_precharging;
            cnt   <= 8'(`DDRC_RP_CYC - 1);
          end else if (state == ddrc_pkg::bk_precharging && cnt == 8'h00) begin
            state <= ddrc_pkg::bk_idle;
          end
        end
        ddrc_pkg::bk_activating: begin
          if (cnt == 8'h00) state <= ddrc_pkg::bk_active;
        end
        ddrc_pkg::bk_active, ddrc_pkg::bk_reading, ddrc_pkg::bk_writing: begin
          if (rd) begin
            state   <= ddrc_pkg::bk_reading;
            cnt     <= rd_len - 8'h01;
            ap_pend <= ap;
          end else if (wr) begin
            state   <= ddrc_pkg::bk_writing;
            cnt     <= wr_len - 8'h01;
            ap_pend <= ap;
          end else if (pre) begin
            state   <= ddrc_pkg::bk_precharging;
            cnt     <= 8'(`DDRC_RP_CYC - 1);
            ap_pend <= 1'b0;
          end else if (state != ddrc_pkg::bk_active && cnt == 8'h00) begin
            // Auto precharge starts after the burst, or after write recovery.
            state   <= ap_pend ? ddrc_pkg::bk_precharging : ddrc_pkg::bk_active;
            cnt     <= 8'(`DDRC_RP_CYC - 1);
            ap_pend <= 1'b0;
          end
        end
        default: state <= ddrc_pkg::bk_idle;
      endcase
    end
  end
endmodule : ddrc_bank
`default_nettype wire

/* File: ddrc_ctrl.sv */
// DDR2 command controller: AHB-Lite register slave driving the memory command pins.
`timescale 1ns/1ps
`default_nettype none
`include "ddrc_cfg.svh"
module ddrc_ctrl (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  output var  logic        ddr_cke,
  output var  logic        ddr_cs_n,
  output var  logic        ddr_ras_n,
  output var  logic        ddr_cas_n,
  output var  logic        ddr_we_n,
  output var  logic [2:0]  ddr_ba,
  output var  logic [13:0] ddr_addr
);
  logic                 dp_wr;
  logic                 dp_rd;
  logic [7:0]           dp_addr;
  logic [3:0]           cmd_raw;
  ddrc_pkg::ddrc_op_e   cmd_op;
  logic                 cmd_ap;
  logic [2:0]           cmd_bank;
  logic [13:0]          cmd_addr;
  logic                 pending;
  logic                 refused;
  logic                 selfref;
  logic                 bl8;
  logic [2:0]           cl;
  ddrc_pkg::ddrc_cnt_t  rd_wait;
  ddrc_pkg::ddrc_cnt_t  wr_wait;
  ddrc_pkg::ddrc_cnt_t  all_wait;
  ddrc_pkg::ddrc_cnt_t  half;
  ddrc_pkg::ddrc_cnt_t  rd_len;
  ddrc_pkg::ddrc_cnt_t  wr_len;
  ddrc_pkg::ddrc_cnt_t  wr_to_rd;
  ddrc_pkg::ddrc_bank_e bank_st [8];
  logic [7:0]           bank_ap;
  ddrc_pkg::ddrc_bank_e sel;
  logic                 any_open;
  logic                 any_busy;
  logic                 all_idle;
  logic                 go;
  logic                 bad;
  logic [31:0]          next_hrdata;
  logic                 wr_cmd;
  logic                 wr_cfg;
  logic                 wr_st;

  assign cmd_op = ddrc_pkg::ddrc_op_e'(cmd_raw);
  assign half = bl8 ? 8'h04 : 8'h02;
  assign rd_len = half;
  assign wr_len = 8'({5'h00, cl} - 8'h01 + half + 8'(`DDRC_WR_CYC));
  assign wr_to_rd = 8'({5'h00, cl} - 8'h01 + half + 8'(`DDRC_WTR_CYC));
  assign wr_cmd = dp_wr && dp_addr == `DDRC_REG_CMD;
  assign wr_cfg = dp_wr && dp_addr == `DDRC_REG_CFG;
  assign wr_st = dp_wr && dp_addr == `DDRC_REG_STATUS;

  // One tracker per bank.
  for (genvar g = 0; g < 8; g++) begin : g_bank
    ddrc_bank u_bank (
      .clk     (clk),
      .reset_n (reset_n),
      .act     (go && cmd_op == ddrc_pkg::op_act && cmd_bank == 3'(g)),
      .rd      (go && cmd_op == ddrc_pkg::op_rd && cmd_bank == 3'(g)),
      .wr      (go && cmd_op == ddrc_pkg::op_wr && cmd_bank == 3'(g)),
      .pre     (go && cmd_op == ddrc_pkg::op_pre && (cmd_ap || cmd_bank == 3'(g))),
      .ap      (cmd_ap),
      .rd_len  (rd_len),
      .wr_len  (wr_len),
      .state   (bank_st[g]),
      .ap_pend (bank_ap[g])
    );
  end

  always_comb begin
    any_open = 1'b0;
    any_busy = 1'b0;
    all_idle = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (bank_st[i] != ddrc_pkg::bk_idle) all_idle = 1'b0;
      if (bank_st[i] == ddrc_pkg::bk_activating || bank_st[i] == ddrc_pkg::bk_reading
          || bank_st[i] == ddrc_pkg::bk_writing) any_busy = 1'b1;
      if (bank_st[i] == ddrc_pkg::bk_active || bank_st[i] == ddrc_pkg::bk_activating
          || ((bank_st[i] == ddrc_pkg::bk_reading || bank_st[i] == ddrc_pkg::bk_writing)
              && !bank_ap[i])) any_open = 1'b1;
    end
  end

  // A waiting order holds until legal, except an activate to a bank with auto precharge pending, which is refused; one that can never become legal is refused.
  always_comb begin
    go = 1'b0;
    bad = 1'b0;
    sel = bank_st[cmd_bank];
    if (pending) begin
      if (selfref && cmd_op != ddrc_pkg::op_srx) begin
        bad = 1'b1;
      end else begin
        unique case (cmd_op)
          ddrc_pkg::op_nop: go = 1'b1;
          ddrc_pkg::op_srx: begin
            if (!selfref) bad = 1'b1;
            else go = 1'b1;
          end
          ddrc_pkg::op_act: begin
            if (sel != ddrc_pkg::bk_idle && sel != ddrc_pkg::bk_precharging) bad = 1'b1;
            else if (sel == ddrc_pkg::bk_idle && all_wait == 8'h00) go = 1'b1;
          end
          ddrc_pkg::op_rd, ddrc_pkg::op_wr: begin
            if (sel == ddrc_pkg::bk_idle || sel == ddrc_pkg::bk_precharging
                || ((sel == ddrc_pkg::bk_reading || sel == ddrc_pkg::bk_writing)
                    && bank_ap[cmd_bank])) bad = 1'b1;
            else if (sel != ddrc_pkg::bk_activating && all_wait == 8'h00
                     && (cmd_op == ddrc_pkg::op_rd ? rd_wait : wr_wait) == 8'h00)
              go = 1'b1;
          end
          ddrc_pkg::op_pre: begin
            if (all_wait == 8'h00 && (cmd_ap ? !any_busy
                : (sel != ddrc_pkg::bk_activating && sel != ddrc_pkg::bk_reading
                   && sel != ddrc_pkg::bk_writing))) go = 1'b1;
          end
          ddrc_pkg::op_mrs, ddrc_pkg::op_ref, ddrc_pkg::op_sre: begin
            if (any_open) bad = 1'b1;
            else if (all_idle && all_wait == 8'h00 && rd_wait == 8'h00
                     && wr_wait == 8'h00) go = 1'b1;
          end
          default: bad = 1'b1;
        endcase
      end
    end
  end

  // Pins: NOP unless an order goes out this edge.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ddr_cs_n  <= 1'b1;
      ddr_ras_n <= 1'b1;
      ddr_cas_n <= 1'b1;
      ddr_we_n  <= 1'b1;
      ddr_ba    <= 3'h0;
      ddr_addr  <= 14'h0000;
    end else begin
      ddr_cs_n  <= 1'b0;
      ddr_ras_n <= 1'b1;
      ddr_cas_n <= 1'b1;
      ddr_we_n  <= 1'b1;
      if (go) begin
        ddr_ba   <= cmd_bank;
        ddr_addr <= cmd_addr;
        unique case (cmd_op)
          ddrc_pkg::op_mrs: begin
            ddr_ras_n <= 1'b0;
            ddr_cas_n <= 1'b0;
            ddr_we_n  <= 1'b0;
          end
          ddrc_pkg::op_act: ddr_ras_n <= 1'b0;
          ddrc_pkg::op_rd, ddrc_pkg::op_wr: begin
            ddr_cas_n    <= 1'b0;
            ddr_we_n     <= cmd_op == ddrc_pkg::op_rd;
            ddr_addr[10] <= cmd_ap;
          end
          ddrc_pkg::op_pre: begin
            ddr_ras_n    <= 1'b0;
            ddr_we_n     <= 1'b0;
            ddr_addr[10] <= cmd_ap;
          end
          ddrc_pkg::op_ref, ddrc_pkg::op_sre: begin
            ddr_ras_n <= 1'b0;
            ddr_cas_n <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // Clock enable drops with self-refresh entry and returns on exit.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ddr_cke <= 1'b0;
      selfref <= 1'b0;
    end else if (go && cmd_op == ddrc_pkg::op_sre) begin
      ddr_cke <= 1'b0;
      selfref <= 1'b1;
    end else if (go && cmd_op == ddrc_pkg::op_srx) begin
      ddr_cke <= 1'b1;
      selfref <= 1'b0;
    end else if (!selfref) begin
      ddr_cke <= 1'b1;
    end
  end

  // Cross-bank spacing counters; a value of zero lets the next order go.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_wait  <= 8'h00;
      wr_wait  <= 8'h00;
      all_wait <= 8'(`DDRC_CKE_WAIT);
    end else begin
      if (rd_wait != 8'h00) rd_wait <= rd_wait - 8'h01;
      if (wr_wait != 8'h00) wr_wait <= wr_wait - 8'h01;
      if (all_wait != 8'h00) all_wait <= all_wait - 8'h01;
      if (go) begin
        unique case (cmd_op)
          ddrc_pkg::op_rd: begin
            rd_wait <= half - 8'h01;
            if (wr_wait < half + 8'h01) wr_wait <= half + 8'h01;
          end
          ddrc_pkg::op_wr: begin
            wr_wait <= half - 8'h01;
            rd_wait <= wr_to_rd - 8'h01;
          end
          ddrc_pkg::op_mrs: all_wait <= 8'(`DDRC_MRD_CYC - 1);
          ddrc_pkg::op_ref: all_wait <= 8'(`DDRC_RFC_CYC - 1);
          ddrc_pkg::op_srx: all_wait <= 8'(`DDRC_XSNR_CYC - 1);
          default: ;
        endcase
      end
    end
  end

  // AHB-Lite address phase capture; only whole-word writes reach a register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_rd <= 1'b0;
      if (hready) begin
        dp_wr   <= hsel && htrans[1] && hwrite && hsize == 3'h2;
        dp_rd   <= hsel && htrans[1] && !hwrite;
        dp_addr <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state so that the read data comes from a flip-flop.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
      if (dp_rd) hrdata <= next_hrdata;
    end
  end

  always_comb begin
    next_hrdata = 32'h0000_0000;
    unique case (dp_addr)
      `DDRC_REG_CMD: begin
        next_hrdata[3:0] = cmd_raw;
        next_hrdata[`DDRC_CMD_AP_BIT] = cmd_ap;
        next_hrdata[`DDRC_CMD_BANK_LSB +: 3] = cmd_bank;
      end
      `DDRC_REG_ADDR: next_hrdata[13:0] = cmd_addr;
      `DDRC_REG_CFG: begin
        next_hrdata[0] = bl8;
        next_hrdata[`DDRC_CFG_CL_LSB +: 3] = cl;
      end
      `DDRC_REG_STATUS: next_hrdata[3:0] = {ddr_cke, selfref, refused, pending};
      `DDRC_REG_BANKS: begin
        for (int i = 0; i < 8; i++) next_hrdata[3*i +: 3] = bank_st[i];
      end
      default: ;
    endcase
  end

  // Order registers; a new order is taken only when none is pending.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_raw  <= 4'h0;
      cmd_ap   <= 1'b0;
      cmd_bank <= 3'h0;
      cmd_addr <= 14'h0000;
      pending  <= 1'b0;
    end else begin
      if (go || bad) pending <= 1'b0;
      if (wr_cmd && !pending) begin
        cmd_raw  <= hwdata[3:0];
        cmd_ap   <= hwdata[`DDRC_CMD_AP_BIT];
        cmd_bank <= hwdata[`DDRC_CMD_BANK_LSB +: 3];
        pending  <= 1'b1;
      end
      if (dp_wr && dp_addr == `DDRC_REG_ADDR && !pending) cmd_addr <= hwdata[13:0];
    end
  end

  // Configuration; a latency outside three to seven is not stored.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bl8 <= 1'b0;
      cl  <= `DDRC_CFG_CL_RST;
    end else if (wr_cfg && !pending && !any_busy) begin
      bl8 <= hwdata[0];
      if (hwdata[`DDRC_CFG_CL_LSB +: 3] >= `DDRC_CL_MIN) cl <= hwdata[`DDRC_CFG_CL_LSB +: 3];
    end
  end

  // Refused flag: a refusal in the clearing cycle wins over the clear.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) refused <= 1'b0;
    else if (bad) refused <= 1'b1;
    else if (wr_st && hwdata[`DDRC_ST_REFUSED_BIT]) refused <= 1'b0;
  end
endmodule : ddrc_ctrl
`default_nettype wire

/* File: ddrc_dev.sv */
// Behavioural DDR2 device that registers the command pins and counts illegal sequences.
`timescale 1ns/1ps
`default_nettype none
module ddrc_dev (
  input  wire logic        clk,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] addr,
  output var  logic [31:0] viol,
  output var  logic [31:0] refreshes,
  output var  logic        in_sr,
  output var  logic [7:0]  bank_open,
  output var  logic [13:0] mode_reg [0:7]
);
  logic       cke_q;
  logic [2:0] cmd;
  assign cmd = {ras_n, cas_n, we_n};
  initial begin
    viol = 0;
    refreshes = 0;
    in_sr = 1'b0;
    bank_open = 8'h00;
    cke_q = 1'b0;
  end
  // An auto-precharge access closes the bank at once; other banks stay free meanwhile.
  always @(posedge clk) begin
    cke_q <= cke;
    if (in_sr) begin
      if (cke) in_sr <= 1'b0;
    end else if (!cs_n && cke_q) begin
      case (cmd)
        3'h7: ;
        3'h0: begin
          if (bank_open != 8'h00) viol <= viol + 1;
          mode_reg[ba] <= addr;
        end
        3'h1: begin
          if (bank_open != 8'h00) viol <= viol + 1;
          if (cke) refreshes <= refreshes + 1;
          else in_sr <= 1'b1;
        end
        3'h3: begin
          if (bank_open[ba]) viol <= viol + 1;
          bank_open[ba] <= 1'b1;
        end
        3'h4, 3'h5: begin
          // No activate-to-column check here, so an early column command is taken.
          if (!bank_open[ba]) viol <= viol + 1;
          if (addr[10]) bank_open[ba] <= 1'b0;
        end
        3'h2: begin
          if (addr[10]) bank_open <= 8'h00;
          else bank_open[ba] <= 1'b0;
        end
        default: viol <= viol + 1;
      endcase
    end
  end
endmodule : ddrc_dev
`default_nettype wire

/* File: ddrc_ctrl_checker.sv */
// Assertion checker for the controller's command pins and bus handshake.
`timescale 1ns/1ps
`default_nettype none
module ddrc_ctrl_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        ddr_cke,
  input wire logic        ddr_cs_n,
  input wire logic        ddr_ras_n,
  input wire logic        ddr_cas_n,
  input wire logic        ddr_we_n,
  input wire logic [2:0]  ddr_ba,
  input wire logic [13:0] ddr_addr
);
  logic [2:0] cmd;
  logic       nop_c, act_c, rd_c, wr_c, pre_c, ref_c, mrs_c;
  logic [7:0] open_q;
  assign cmd = {ddr_ras_n, ddr_cas_n, ddr_we_n};
  assign nop_c = ddr_cs_n || cmd == 3'h7;
  assign act_c = !ddr_cs_n && cmd == 3'h3;
  assign rd_c = !ddr_cs_n && cmd == 3'h5;
  assign wr_c = !ddr_cs_n && cmd == 3'h4;
  assign pre_c = !ddr_cs_n && cmd == 3'h2;
  assign ref_c = !ddr_cs_n && cmd == 3'h1;
  assign mrs_c = !ddr_cs_n && cmd == 3'h0;
  // Only open rows are tracked, so the limits below are the loosest legal ones.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) open_q <= 8'h00;
    else if (act_c) open_q[ddr_ba] <= 1'b1;
    else if (pre_c && ddr_addr[10]) open_q <= 8'h00;
    else if (pre_c || ((rd_c || wr_c) && ddr_addr[10])) open_q[ddr_ba] <= 1'b0;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence quiet2;
    nop_c ##1 nop_c;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_cmd_one_cycle: assert property (!nop_c |=> nop_c)
    else $error("command held longer than one cycle");
  a_cke_wait: assert property ($rose(ddr_cke) |-> quiet2)
    else $error("command too soon after clock enable rose");
  a_mrs_idle: assert property ((mrs_c || ref_c) |-> open_q == 8'h00)
    else $error("mode load or refresh with a row open");
  a_act_closed: assert property (act_c |-> !open_q[ddr_ba])
    else $error("activate to a bank with an open row");
  a_rdwr_open: assert property ((rd_c || wr_c) |-> open_q[ddr_ba])
    else $error("column access to a closed bank");
  a_ref_gap: assert property ((ref_c && ddr_cke) |=> nop_c [*5])
    else $error("command inside the refresh time");
  a_wr_rd_gap: assert property (wr_c |=> !rd_c [*5])
    else $error("read too soon after write");
  a_rd_wr_gap: assert property (rd_c |=> !wr_c [*3])
    else $error("write too soon after read");
  a_sre_cke: assert property ($fell(ddr_cke) |-> ref_c)
    else $error("clock enable fell without self refresh entry");
  a_read_wait: assert property ((hsel && hready && htrans[1] && !hwrite) |=> rd_wait)
    else $error("read data phase not one wait state");
endmodule : ddrc_ctrl_checker
bind ddrc_ctrl ddrc_ctrl_checker i_ddrc_ctrl_checker (.clk(clk), .reset_n(reset_n),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n),
  .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr));
`default_nettype wire

/* File: test_ddrc_ctrl.sv */
// Self-checking bench for the DDR2 command controller driven over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ddrc_cfg.svh"
module test_ddrc_ctrl;
  logic        clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic        ddr_cke, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n, dev_in_sr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ddr_ba;
  logic [13:0] ddr_addr;
  logic [13:0] dev_mode [0:7];
  logic [7:0]  dev_open;
  logic [19:0] last_pins;
  logic [31:0] haddr, hwdata, hrdata, rv, dev_viol, dev_ref;
  wire logic   hready;
  int          err_count = 0, n_tests = 0, n_cmd = 0, cyc = 0, last_cyc = 0, prev_cyc = 0;
  int          n, k0;
  localparam int CL = 7, BL = 8;
  assign hready = hreadyout;
  ddrc_ctrl i_ddrc_ctrl (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ddr_cke(ddr_cke),
    .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n), .ddr_cas_n(ddr_cas_n),
    .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr));
  ddrc_dev i_ddrc_dev (.clk(clk), .cke(ddr_cke), .cs_n(ddr_cs_n), .ras_n(ddr_ras_n),
    .cas_n(ddr_cas_n), .we_n(ddr_we_n), .ba(ddr_ba), .addr(ddr_addr), .viol(dev_viol),
    .refreshes(dev_ref), .in_sr(dev_in_sr), .bank_open(dev_open), .mode_reg(dev_mode));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Pins are read at the edge where the device registers them.
  always @(posedge clk) begin
    cyc++;
    if (reset_n === 1'b1 && ddr_cs_n === 1'b0 && {ddr_ras_n, ddr_cas_n, ddr_we_n} !== 3'h7) begin
      n_cmd++;
      prev_cyc = last_cyc;
      last_cyc = cyc;
      last_pins = {ddr_ras_n, ddr_cas_n, ddr_we_n, ddr_ba, ddr_addr};
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_ready();
    int w = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      w++;
      if (w > 20) begin
        err_count++;
        give_verdict();
      end
      @(posedge clk);
    end
  endtask : wait_ready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer
  // Leaves the final status word in rv so callers can see a refusal.
  task automatic issue(input logic [3:0] op, input logic ap, input logic [2:0] bk,
                       input logic [13:0] ad);
    int p = 0;
    xfer(1'b1, `DDRC_REG_ADDR, {18'h00000, ad}, rv);
    xfer(1'b1, `DDRC_REG_CMD, {21'h000000, bk, 3'h0, ap, op}, rv);
    rv = 32'h00000001;
    while (rv[0] !== 1'b0 && p < 40) begin
      xfer(1'b0, `DDRC_REG_STATUS, 32'h00000000, rv);
      p++;
    end
    if (rv[0] !== 1'b0) begin
      err_count++;
      give_verdict();
    end
  endtask : issue
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    xfer(1'b0, `DDRC_REG_CFG, 32'h00000000, rv);
    check(rv, {25'h0000000, `DDRC_CFG_CL_RST, 4'h0});
    xfer(1'b0, `DDRC_REG_STATUS, 32'h00000000, rv);
    check(rv, 32'h00000008);
    xfer(1'b0, 8'h20, 32'h00000000, rv);
    check(rv, 32'h00000000);
    check(hresp, 1'b0);
    xfer(1'b1, `DDRC_REG_CFG, 32'h00000021, rv);
    xfer(1'b0, `DDRC_REG_CFG, 32'h00000000, rv);
    check(rv, 32'h00000031);
    xfer(1'b1, `DDRC_REG_CFG, {25'h0000000, 3'(CL), 4'h1}, rv);
    xfer(1'b0, `DDRC_REG_CFG, 32'h00000000, rv);
    check(rv, 32'h00000071);
    $display("test config done");
    issue(4'h1, 1'b0, 3'h3, 14'h0A52);
    check(dev_mode[3], 32'h00000A52);
    for (int i = 0; i < 8; i++) begin
      issue(4'h2, 1'b0, i[2:0], 14'h0100 + 14'(i));
      check(last_pins, {3'h3, i[2:0], 14'h0100 + 14'(i)});
    end
    xfer(1'b0, `DDRC_REG_BANKS, 32'h00000000, rv);
    check(rv, 32'h00492492);
    issue(4'h1, 1'b0, 3'h0, 14'h0000);
    check(rv[1], 1'b1);
    xfer(1'b1, `DDRC_REG_STATUS, 32'h00000002, rv);
    $display("test activate done");
    issue(4'h4, 1'b0, 3'h1, 14'h0008);
    check(last_pins, {3'h4, 3'h1, 14'h0008});
    issue(4'h3, 1'b1, 3'h0, 14'h0010);
    check(last_pins, {3'h5, 3'h0, 14'h0410});
    check(last_cyc - prev_cyc, (CL - 1) + BL / 2 + 2);
    issue(4'h4, 1'b1, 3'h3, 14'h0020);
    check(last_pins, {3'h4, 3'h3, 14'h0420});
    check(last_cyc - prev_cyc >= BL / 2 + 2, 1'b1);
    k0 = n_cmd;
    issue(4'h3, 1'b0, 3'h0, 14'h0000);
    check(rv[1], 1'b1);
    check(n_cmd, k0);
    xfer(1'b1, `DDRC_REG_STATUS, 32'h00000002, rv);
    $display("test bursts done");
    issue(4'h5, 1'b1, 3'h0, 14'h0000);
    check(last_pins, {3'h2, 3'h0, 14'h0400});
    n = 0;
    rv = 32'h00000001;
    while (rv !== 32'h00000000 && n < 20) begin
      xfer(1'b0, `DDRC_REG_BANKS, 32'h00000000, rv);
      n++;
    end
    check(rv, 32'h00000000);
    issue(4'h6, 1'b0, 3'h5, 14'h1FFF);
    check(dev_ref, 32'h00000001);
    issue(4'h7, 1'b0, 3'h0, 14'h0000);
    check(rv[3:0], 4'h4);
    check(dev_in_sr, 1'b1);
    issue(4'h2, 1'b0, 3'h0, 14'h0000);
    check(rv[3:0], 4'h6);
    xfer(1'b1, `DDRC_REG_STATUS, 32'h00000002, rv);
    issue(4'h8, 1'b0, 3'h0, 14'h0000);
    check(rv[3:0], 4'h8);
    for (int k = 8; k < 10; k++) begin
      issue(4'(k), 1'b0, 3'h0, 14'h0000);
      check(rv[1], 1'b1);
      xfer(1'b1, `DDRC_REG_STATUS, 32'h00000002, rv);
    end
    // Burst length four with the same latency shortens the write-to-read spacing.
    xfer(1'b1, `DDRC_REG_CFG, {25'h0000000, 3'(CL), 4'h0}, rv);
    xfer(1'b0, `DDRC_REG_CFG, 32'h00000000, rv);
    check(rv, 32'h00000070);
    issue(4'h2, 1'b0, 3'h2, 14'h0007);
    issue(4'h4, 1'b0, 3'h2, 14'h0001);
    issue(4'h3, 1'b0, 3'h2, 14'h0002);
    check(last_pins, {3'h5, 3'h2, 14'h0002});
    check(last_cyc - prev_cyc, (CL - 1) + 4 / 2 + `DDRC_WTR_CYC);
    check(dev_viol, 32'h00000000);
    $display("test refresh done");
    give_verdict();
  end
endmodule : test_ddrc_ctrl
`default_nettype wire
